// ---- twe_controller.sv ----
// Controller end: write FIFO and bit-level two-wire sequencer
`timescale 1ns/1ps
`include "twe_defines.svh"
module twe_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = `TWE_FIFO_DEPTH
)(
  // System
  input  wire logic             clock,
  input  wire logic             sys_rst,
  // Fill side
  input  wire logic             in_valid,
  input  wire logic [WIDTH-1:0] in_data,
  output logic                  in_ready,
  // Drain side
  output logic                  out_valid,
  output logic [WIDTH-1:0]      out_data,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  generate
    if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
      $error("DEPTH must be a power of two of at least 2");
    end
  endgenerate
  logic [WIDTH-1:0] store [DEPTH];
  logic [AW:0]      wp_reg, rp_reg;
  wire              full  = (wp_reg == {~rp_reg[AW], rp_reg[AW-1:0]});
  wire              empty = (wp_reg == rp_reg);
  wire              push  = in_valid & ~full;
  wire              pop   = out_ready & ~empty;
  always_ff @(posedge clock) begin
    if (push) begin
      store[wp_reg[AW-1:0]] <= in_data;
    end
  end
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      wp_reg <= '0;
      rp_reg <= '0;
    end else begin
      wp_reg <= wp_reg + (AW+1)'(push);
      rp_reg <= rp_reg + (AW+1)'(pop);
    end
  end
  assign in_ready  = ~full;
  assign out_valid = ~empty;
  assign out_data  = store[rp_reg[AW-1:0]];
endmodule

module twe_controller
  import twe_pkg::*;
#(
  parameter int QTR        = `TWE_SCL_QTR_CYCLES,
  parameter int FIFO_DEPTH = `TWE_FIFO_DEPTH
)(
  // System
  input  wire logic                   clock,
  input  wire logic                   sys_rst,
  // Link
  twe_bus_if.ctl                      bus,
  // Command
  input  wire logic                   cmd_valid,
  input  wire logic                   cmd_read,
  input  wire logic                   cmd_recover,
  input  wire logic [`TWE_ADDR_W-1:0] cmd_addr,
  input  wire logic [7:0]             cmd_count,
  output logic                        cmd_ready,
  // Write data
  input  wire logic                   wr_valid,
  input  wire logic [7:0]             wr_data,
  output logic                        wr_ready,
  // Read data and status
  output logic                        rd_valid,
  output logic [7:0]                  rd_data,
  output logic                        nack,
  output logic                        done
);
  localparam int QW = (QTR > 1) ? $clog2(QTR) : 1;
  generate
    if (QTR < 1) begin : g_bad_qtr
      $error("QTR must be at least 1");
    end
  endgenerate

  // ==========================================================
  // Write data buffer; drains only while a write is on the wire
  logic       f_valid;
  logic [7:0] f_data;
  twe_ctl_state_t state_reg;
  wire        f_pop = (state_reg == TWE_C_WAITD) & f_valid;
  twe_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
    .clock     (clock),
    .sys_rst   (sys_rst),
    .in_valid  (wr_valid),
    .in_data   (wr_data),
    .in_ready  (wr_ready),
    .out_valid (f_valid),
    .out_data  (f_data),
    .out_ready (f_pop)
  );

  // ==========================================================
  // Sequencer
  logic          sda_meta_reg, sda_sync_reg;
  logic [QW-1:0] qcnt_reg;
  logic [1:0]    q_reg;
  logic [3:0]    bit_reg;
  logic [7:0]    tx_reg, rx_reg, left_reg;
  logic          ackd_reg, is_addr_reg, rd_mode_reg, recov_reg, sda_hi_reg;
  logic          scl_reg, oe_reg, ready_reg, rdv_reg, nack_reg, done_reg;
  logic [7:0]    rdd_reg;
  logic [`TWE_ADDR_W-1:0] addr_reg;

  wire running = (state_reg != TWE_C_IDLE) & (state_reg != TWE_C_WAITD);
  wire tick    = running & (qcnt_reg == QW'(QTR - 1));
  wire last_b  = (bit_reg == `TWE_ACK_SLOT);
  wire more    = (left_reg > 8'h01);
  wire [7:0] wr_len = (cmd_count > `TWE_MAX_PAGE_LEN) ? `TWE_MAX_PAGE_LEN : cmd_count;
  wire [7:0] len    = cmd_read ? cmd_count : wr_len;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
    end else begin
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
    end
  end

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg <= TWE_C_IDLE;
      qcnt_reg  <= '0;
      q_reg     <= 2'h0;
      bit_reg   <= 4'h0;
      {tx_reg, rx_reg, left_reg, rdd_reg} <= 32'h0000_0000;
      {ackd_reg, is_addr_reg, rd_mode_reg, recov_reg, sda_hi_reg} <= 5'h00;
      addr_reg  <= 7'h00;
      scl_reg   <= 1'b1;
      oe_reg    <= 1'b0;
      ready_reg <= 1'b1;
      {rdv_reg, nack_reg, done_reg} <= 3'h0;
    end else begin
      {rdv_reg, nack_reg, done_reg} <= 3'h0;
      qcnt_reg <= tick ? '0 : (running ? qcnt_reg + QW'(1) : '0);
      if (tick) begin
        q_reg <= q_reg + 2'h1;
      end
      case (state_reg)
        TWE_C_IDLE: begin
          q_reg <= 2'h0;
          bit_reg <= 4'h0;
          if (ready_reg & cmd_recover) begin
            state_reg <= TWE_C_RECOV;
            ready_reg <= 1'b0;
          end else if (ready_reg & cmd_valid) begin
            state_reg   <= TWE_C_START;
            ready_reg   <= 1'b0;
            addr_reg    <= cmd_addr;
            rd_mode_reg <= cmd_read;
            left_reg    <= (len == 8'h00) ? 8'h01 : len;
            recov_reg   <= 1'b0;
          end
        end
        TWE_C_START: if (tick) begin
          case (q_reg)
            2'h0: begin scl_reg <= 1'b1; oe_reg <= 1'b0; end
            2'h2: oe_reg <= 1'b1;
            2'h3: begin
              scl_reg     <= 1'b0;
              state_reg   <= recov_reg ? TWE_C_STOP : TWE_C_SEND;
              tx_reg      <= {addr_reg, rd_mode_reg};
              bit_reg     <= 4'h0;
              is_addr_reg <= 1'b1;
            end
            default: ;
          endcase
        end
        TWE_C_SEND: if (tick) begin
          case (q_reg)
            2'h0: oe_reg <= last_b ? 1'b0 : ~tx_reg[7];
            2'h1: scl_reg <= 1'b1;
            2'h2: ackd_reg <= last_b & ~sda_sync_reg;
            default: begin
              scl_reg <= 1'b0;
              if (!last_b) begin
                tx_reg  <= {tx_reg[6:0], 1'b0};
                bit_reg <= bit_reg + 4'h1;
              end else begin
                bit_reg     <= 4'h0;
                is_addr_reg <= 1'b0;
                if (is_addr_reg & ~ackd_reg) begin
                  nack_reg  <= 1'b1;
                  state_reg <= TWE_C_STOP;
                end else if (is_addr_reg) begin
                  state_reg <= rd_mode_reg ? TWE_C_RECV : TWE_C_WAITD;
                end else if (more) begin
                  left_reg  <= left_reg - 8'h01;
                  state_reg <= TWE_C_WAITD;
                end else begin
                  state_reg <= TWE_C_STOP;
                end
              end
            end
          endcase
        end
        TWE_C_WAITD: if (f_valid) begin
          tx_reg    <= f_data;
          state_reg <= TWE_C_SEND;
        end
        TWE_C_RECV: if (tick) begin
          case (q_reg)
            2'h0: oe_reg <= last_b & more;
            2'h1: scl_reg <= 1'b1;
            2'h2: if (!last_b) rx_reg <= {rx_reg[6:0], sda_sync_reg};
            default: begin
              scl_reg <= 1'b0;
              bit_reg <= last_b ? 4'h0 : bit_reg + 4'h1;
              if (bit_reg == 4'h7) begin
                rdv_reg <= 1'b1;
                rdd_reg <= rx_reg;
              end
              if (last_b) begin
                left_reg <= left_reg - 8'h01;
                if (!more) state_reg <= TWE_C_STOP;
              end
            end
          endcase
        end
        TWE_C_STOP: if (tick) begin
          case (q_reg)
            2'h0: begin scl_reg <= 1'b0; oe_reg <= 1'b1; end
            2'h1: scl_reg <= 1'b1;
            2'h2: oe_reg <= 1'b0;
            default: begin
              state_reg <= TWE_C_IDLE;
              ready_reg <= 1'b1;
              done_reg  <= 1'b1;
            end
          endcase
        end
        TWE_C_RECOV: if (tick) begin
          case (q_reg)
            2'h0: oe_reg <= 1'b0;
            2'h1: scl_reg <= 1'b1;
            2'h2: sda_hi_reg <= sda_sync_reg;
            default: begin
              bit_reg <= bit_reg + 4'h1;
              if (sda_hi_reg) begin
                recov_reg <= 1'b1;
                state_reg <= TWE_C_START;
              end else begin
                scl_reg <= 1'b0;
                if (bit_reg == `TWE_RECOVER_CLOCKS - 4'h1) state_reg <= TWE_C_STOP;
              end
            end
          endcase
        end
        default: state_reg <= TWE_C_IDLE;
      endcase
    end
  end

  assign bus.scl        = scl_reg;
  assign bus.ctl_sda_o  = 1'b0;
  assign bus.ctl_sda_oe = oe_reg;
  assign cmd_ready      = ready_reg;
  assign rd_valid       = rdv_reg;
  assign rd_data        = rdd_reg;
  assign nack           = nack_reg;
  assign done           = done_reg;
endmodule

// ---- twe_defines.svh ----
// Timing, geometry and layout constants for the two-wire EEPROM port
`ifndef TWE_DEFINES_SVH
`define TWE_DEFINES_SVH
`define TWE_CLK_NS         40
`define TWE_ADDR_W         7
`define TWE_MEM_WORDS      128
`define TWE_PAGE_BYTES     4
`define TWE_PAGE_BITS      2
`define TWE_WORD_BITS      8
`define TWE_ACK_SLOT       4'h8
`define TWE_WR_TIME_NS     5000000
`define TWE_WR_CYCLES      (`TWE_WR_TIME_NS / `TWE_CLK_NS)
`define TWE_SCL_PERIOD_NS  320
`define TWE_SCL_QTR_CYCLES (`TWE_SCL_PERIOD_NS / 4 / `TWE_CLK_NS)
`define TWE_RECOVER_CLOCKS 4'h9
`define TWE_FIFO_DEPTH     8
`define TWE_MAX_PAGE_LEN   8'h04
`endif

// ---- twe_pkg.sv ----
// Types shared by both ends of the two-wire EEPROM port
package twe_pkg;
  typedef enum logic [2:0] {TWE_D_IDLE, TWE_D_ADDR, TWE_D_WDATA, TWE_D_RDATA,
                            TWE_D_BUSY} twe_dev_state_t;
  typedef enum logic [2:0] {TWE_C_IDLE, TWE_C_START, TWE_C_SEND, TWE_C_WAITD,
                            TWE_C_RECV, TWE_C_STOP, TWE_C_RECOV} twe_ctl_state_t;
endpackage

// ---- twe_bus_if.sv ----
// Two-wire link between the controller and the EEPROM end
`timescale 1ns/1ps
interface twe_bus_if;
  logic scl;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic ctl_sda_o;
  logic ctl_sda_oe;
  logic sda;
  // Open-drain wired-AND with pull-up
  assign sda = ~((dev_sda_oe & ~dev_sda_o) | (ctl_sda_oe & ~ctl_sda_o));
  modport dev (input scl, input sda, output dev_sda_o, output dev_sda_oe);
  modport ctl (output scl, input sda, output ctl_sda_o, output ctl_sda_oe);
endinterface

// ---- twe_device.sv ----
// EEPROM end: start/stop detection, word shifter, page buffer and memory
// Operation
// - Data changes only while clock low
// - Falling data, clock high, is start
// - Rising data, clock high, is stop
// - Receiver acknowledges each word on ninth clock, except the last word of a read
// - Device acknowledges every address and write data word, except addresses during the self-timed write
// - Standby at power-up and after stop; after a write stop, only once the internal write ends
// - Controller recovers with nine clocks, then start; code stops clocking once data reads high, then sends start and stop
// - Byte write: address, data, then stop
// - Self-timed write ignores all inputs
// - Page write carries up to four bytes
// - Page write wraps within low two bits
// - Polling acknowledged only after write completes
// - Read sets the direction bit high
// - Byte read: eight bits, no acknowledge, stop
// - Sequential read increments, wraps top to bottom
// - Storage is 32 pages of four bytes
// - Capture on rising, drive after falling clock
`timescale 1ns/1ps
`include "twe_defines.svh"
module twe_device
  import twe_pkg::*;
#(
  parameter int WR_CYCLES = `TWE_WR_CYCLES
)(
  // System
  input  wire logic clock,
  input  wire logic sys_rst,
  // Link
  twe_bus_if.dev    bus,
  // Status
  output logic      busy,
  output logic      standby
);
  localparam int CW = $clog2(WR_CYCLES + 1);

  generate
    if (WR_CYCLES < 1) begin : g_bad_wr
      $error("WR_CYCLES must be at least 1");
    end
  endgenerate

  function automatic logic [`TWE_ADDR_W-1:0] twe_inc(input logic [`TWE_ADDR_W-1:0] a,
                                                    input logic page);
    logic [`TWE_ADDR_W-1:0] s;
    s = a + 7'h01;
    twe_inc = page ? {a[`TWE_ADDR_W-1:`TWE_PAGE_BITS], s[`TWE_PAGE_BITS-1:0]} : s;
  endfunction

  // ==========================================================
  // Storage
  logic [`TWE_WORD_BITS-1:0]  mem [`TWE_MEM_WORDS];
  logic [`TWE_WORD_BITS-1:0]  pbuf [`TWE_PAGE_BYTES];

  // ==========================================================
  // Pin synchronisers and edge detection
  logic                       scl_meta_reg, scl_sync_reg, scl_prev_reg;
  logic                       sda_meta_reg, sda_sync_reg, sda_prev_reg;
  twe_dev_state_t             state_reg;
  logic [3:0]                 bit_cnt_reg;
  logic                       ack_phase_reg;
  logic                       mack_reg;
  logic                       rw_reg;
  logic [`TWE_WORD_BITS-1:0]  rx_reg;
  logic [`TWE_WORD_BITS-1:0]  tx_reg;
  logic [`TWE_ADDR_W-1:0]     addr_reg;
  logic [`TWE_PAGE_BYTES-1:0] pmask_reg;
  logic [CW-1:0]              wr_cnt_reg;
  logic                       sda_oe_reg;
  logic                       busy_reg;
  logic                       standby_reg;

  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_meta_reg <= 1'b1;
      scl_sync_reg <= 1'b1;
      scl_prev_reg <= 1'b1;
      sda_meta_reg <= 1'b1;
      sda_sync_reg <= 1'b1;
      sda_prev_reg <= 1'b1;
    end else begin
      scl_meta_reg <= bus.scl;
      scl_sync_reg <= scl_meta_reg;
      scl_prev_reg <= scl_sync_reg;
      sda_meta_reg <= bus.sda;
      sda_sync_reg <= sda_meta_reg;
      sda_prev_reg <= sda_sync_reg;
    end
  end

  wire scl_rise   = scl_sync_reg & ~scl_prev_reg;
  wire scl_fall   = ~scl_sync_reg & scl_prev_reg;
  wire scl_high   = scl_sync_reg & scl_prev_reg;
  wire start_seen = scl_high & sda_prev_reg & ~sda_sync_reg;
  wire stop_seen  = scl_high & ~sda_prev_reg & sda_sync_reg;
  wire in_busy    = (state_reg == TWE_D_BUSY);
  wire active     = (state_reg != TWE_D_IDLE) & ~in_busy;
  wire byte_done  = active & scl_fall & (bit_cnt_reg == `TWE_ACK_SLOT) & ~ack_phase_reg;
  wire ack_end    = active & scl_fall & ack_phase_reg;
  wire commit     = ~in_busy & ~start_seen & stop_seen & (pmask_reg != '0);
  wire wr_done    = in_busy & (wr_cnt_reg == CW'(WR_CYCLES - 1));
  wire [`TWE_ADDR_W-1:0]    seq_addr = twe_inc(addr_reg, 1'b0);
  wire [`TWE_ADDR_W-1:0]    pg_addr  = twe_inc(addr_reg, 1'b1);
  wire [`TWE_WORD_BITS-1:0] rd_first = mem[addr_reg];
  wire [`TWE_WORD_BITS-1:0] rd_next  = mem[seq_addr];
  wire [`TWE_PAGE_BITS-1:0] slot     = addr_reg[`TWE_PAGE_BITS-1:0];
  wire                      wr_byte  = byte_done & (state_reg == TWE_D_WDATA);

  // ==========================================================
  // Memory and page buffer (no reset: contents survive sys_rst)
  always_ff @(posedge clock) begin
    if (wr_byte) begin
      pbuf[slot] <= rx_reg;
    end
    if (commit) begin
      for (int i = 0; i < `TWE_PAGE_BYTES; i++) begin
        if (pmask_reg[i]) begin
          mem[{addr_reg[`TWE_ADDR_W-1:`TWE_PAGE_BITS], i[`TWE_PAGE_BITS-1:0]}] <= pbuf[i];
        end
      end
    end
  end

  // ==========================================================
  // Word sequencer
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      state_reg     <= TWE_D_IDLE;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      mack_reg      <= 1'b0;
      rw_reg        <= 1'b0;
      rx_reg        <= 8'h00;
      tx_reg        <= 8'h00;
      addr_reg      <= 7'h00;
      pmask_reg     <= 4'h0;
      wr_cnt_reg    <= '0;
      sda_oe_reg    <= 1'b0;
    end else if (in_busy) begin
      // Deaf while the cell write runs, so polling gets no acknowledge
      sda_oe_reg <= 1'b0;
      wr_cnt_reg <= wr_cnt_reg + CW'(1);
      if (wr_done) begin
        state_reg <= TWE_D_IDLE;
      end
    end else if (start_seen) begin
      state_reg     <= TWE_D_ADDR;
      bit_cnt_reg   <= 4'h0;
      ack_phase_reg <= 1'b0;
      sda_oe_reg    <= 1'b0;
      pmask_reg     <= 4'h0;
    end else if (stop_seen) begin
      sda_oe_reg <= 1'b0;
      pmask_reg  <= 4'h0;
      wr_cnt_reg <= '0;
      state_reg  <= commit ? TWE_D_BUSY : TWE_D_IDLE;
    end else if (active) begin
      if (scl_rise & ~ack_phase_reg) begin
        rx_reg      <= {rx_reg[6:0], sda_sync_reg};
        bit_cnt_reg <= bit_cnt_reg + 4'h1;
      end
      if (scl_rise & ack_phase_reg) begin
        mack_reg <= ~sda_sync_reg;
      end
      if (byte_done) begin
        ack_phase_reg <= 1'b1;
        sda_oe_reg    <= (state_reg != TWE_D_RDATA);
        if (state_reg == TWE_D_ADDR) begin
          addr_reg <= rx_reg[7:1];
          rw_reg   <= rx_reg[0];
        end
        if (wr_byte) begin
          pmask_reg[slot] <= 1'b1;
          addr_reg        <= pg_addr;
        end
      end else if (ack_end) begin
        ack_phase_reg <= 1'b0;
        bit_cnt_reg   <= 4'h0;
        sda_oe_reg    <= 1'b0;
        if (state_reg == TWE_D_ADDR) begin
          state_reg <= rw_reg ? TWE_D_RDATA : TWE_D_WDATA;
          if (rw_reg) begin
            tx_reg     <= rd_first;
            sda_oe_reg <= ~rd_first[7];
          end
        end else if (state_reg == TWE_D_RDATA) begin
          if (mack_reg) begin
            addr_reg   <= seq_addr;
            tx_reg     <= rd_next;
            sda_oe_reg <= ~rd_next[7];
          end else begin
            state_reg <= TWE_D_IDLE;
          end
        end
      end else if (scl_fall & (state_reg == TWE_D_RDATA)) begin
        tx_reg     <= {tx_reg[6:0], 1'b0};
        sda_oe_reg <= ~tx_reg[6];
      end
    end
  end

  // ==========================================================
  // Status outputs
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      busy_reg    <= 1'b0;
      standby_reg <= 1'b1;
    end else begin
      busy_reg    <= in_busy;
      standby_reg <= (state_reg == TWE_D_IDLE);
    end
  end

  assign busy           = busy_reg;
  assign standby        = standby_reg;
  assign bus.dev_sda_o  = 1'b0;
  assign bus.dev_sda_oe = sda_oe_reg;
endmodule

// ---- twe_link_monitor.sv ----
// Checker for the two-wire link between controller and EEPROM end
`timescale 1ns/1ps
module twe_link_monitor #(
  parameter int WR_CYCLES = 400
)(
  // System
  input wire logic clock,
  input wire logic sys_rst,
  // Link
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_sda_oe,
  // Device status
  input wire logic busy,
  input wire logic standby
);
  // ==========================================
  // Frame tracking
  logic        scl_reg, sda_reg, act_reg, first_reg, rd_reg, ign_reg;
  logic [3:0]  cnt_reg;
  logic [31:0] bcnt_reg;
  wire       rise_w  = scl & ~scl_reg;
  wire       start_w = scl & scl_reg & sda_reg & ~sda;
  wire       stop_w  = scl & scl_reg & ~sda_reg & sda;
  wire       ack_w   = rise_w & act_reg & (cnt_reg == 4'h8);
  wire [3:0] cnt_wrap = (cnt_reg == 4'h9) ? 4'h1 : cnt_reg + 4'h1;
  wire [3:0] cnt_next = start_w ? 4'h0 : (rise_w ? cnt_wrap : cnt_reg);
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      scl_reg  <= 1'b1;
      sda_reg  <= 1'b1;
      cnt_reg  <= 4'h0;
      bcnt_reg <= 32'h0;
    end else begin
      scl_reg  <= scl;
      sda_reg  <= sda;
      cnt_reg  <= cnt_next;
      bcnt_reg <= busy ? bcnt_reg + 32'h1 : 32'h0;
    end
  end
  // Busy is sampled at the start so a late ack near write end is not misjudged
  always_ff @(posedge clock or posedge sys_rst) begin
    if (sys_rst) begin
      act_reg   <= 1'b0;
      first_reg <= 1'b0;
      rd_reg    <= 1'b0;
      ign_reg   <= 1'b0;
    end else if (start_w) begin
      act_reg   <= 1'b1;
      first_reg <= 1'b1;
      ign_reg   <= busy;
    end else if (stop_w) begin
      act_reg <= 1'b0;
    end else if (ack_w) begin
      first_reg <= 1'b0;
    end else if (rise_w & first_reg & (cnt_reg == 4'h7)) begin
      rd_reg <= sda;
    end
  end
  // ==========================================
  // Assertions
  default clocking cb @(posedge clock); endclocking
  default disable iff (sys_rst);
  sequence s_start_hold;
    scl ##1 scl;
  endsequence
  sequence s_settle;
    ##[1:8] (standby | busy);
  endsequence
  a_dev_moves_low: assert property ($changed(dev_sda_oe) |-> !$past(scl))
    else $error("device changed data while clock high");
  a_start_hold: assert property (start_w |-> s_start_hold)
    else $error("clock fell too soon after start");
  a_word_acked: assert property (ack_w & ~ign_reg & (first_reg | ~rd_reg) |-> !sda)
    else $error("received word not acknowledged");
  a_busy_no_ack: assert property (ack_w & first_reg & ign_reg & busy |-> sda)
    else $error("acknowledge given during internal write");
  a_read_released: assert property (ack_w & ~first_reg & rd_reg |-> !dev_sda_oe)
    else $error("device held data line in read ack slot");
  a_stop_standby: assert property (stop_w |-> s_settle)
    else $error("no standby or write after stop");
  a_busy_span: assert property ($fell(busy) |-> (bcnt_reg >= WR_CYCLES - 1) &&
    (bcnt_reg <= WR_CYCLES + 1))
    else $error("internal write length wrong");
  a_busy_quiet: assert property (busy |-> !dev_sda_oe)
    else $error("device drove link while busy");
endmodule

// ---- two_wire_eeprom_port_bench.sv ----
// Bench joining the controller and EEPROM end on one link
`timescale 1ns/1ps
module two_wire_eeprom_port_bench;
  localparam int WR_CYC = 400;
  logic       clock, sys_rst, cmd_valid, cmd_read, cmd_recover, wr_valid;
  logic       cmd_ready, wr_ready, rd_valid, nack, done, busy, standby;
  logic [6:0] cmd_addr;
  logic [7:0] cmd_count, wr_data, rd_data;
  logic [7:0] got_q[$];
  logic       bit_q[$];
  int         n_mismatch, checked, nack_n;
  // ==========================================
  // Design
  twe_bus_if u_twe_bus_if ();
  twe_device #(.WR_CYCLES(WR_CYC)) u_twe_device (.clock(clock), .sys_rst(sys_rst),
    .bus(u_twe_bus_if.dev), .busy(busy), .standby(standby));
  twe_controller u_twe_controller (.clock(clock), .sys_rst(sys_rst), .bus(u_twe_bus_if.ctl),
    .cmd_valid(cmd_valid), .cmd_read(cmd_read), .cmd_recover(cmd_recover),
    .cmd_addr(cmd_addr), .cmd_count(cmd_count), .cmd_ready(cmd_ready), .wr_valid(wr_valid),
    .wr_data(wr_data), .wr_ready(wr_ready), .rd_valid(rd_valid), .rd_data(rd_data),
    .nack(nack), .done(done));
  twe_link_monitor #(.WR_CYCLES(WR_CYC)) u_twe_link_monitor (.clock(clock),
    .sys_rst(sys_rst), .scl(u_twe_bus_if.scl), .sda(u_twe_bus_if.sda),
    .dev_sda_oe(u_twe_bus_if.dev_sda_oe), .busy(busy), .standby(standby));
  initial begin
    clock = 1'b0;
    forever #20 clock = ~clock;
  end
  // Bits seen on the wire at each clock rise, cleared by a start
  always @(posedge u_twe_bus_if.scl) bit_q.push_back(u_twe_bus_if.sda);
  always @(negedge u_twe_bus_if.sda) if (u_twe_bus_if.scl === 1'b1) bit_q = {};
  // ==========================================
  // Tasks
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic give_verdict();
    if (n_mismatch == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // One edge first, so valid never drops and rises in the same step
  task automatic push(input logic [7:0] d);
    int k;
    k = 0;
    do begin
      @(negedge clock);
      k++;
    end while (wr_ready !== 1'b1 && k < 500);
    wr_valid = 1'b1;
    wr_data = d;
    @(negedge clock);
    wr_valid = 1'b0;
  endtask
  task automatic run(input logic rd, input logic rec, input logic [6:0] a, input logic [7:0] n);
    int k;
    logic [7:0] w;
    got_q = {};
    nack_n = 0;
    for (k = 0; k < 100 && cmd_ready !== 1'b1; k++) @(negedge clock);
    cmd_valid = ~rec;
    cmd_recover = rec;
    cmd_read = rd;
    cmd_addr = a;
    cmd_count = n;
    @(negedge clock);
    cmd_valid = 1'b0;
    cmd_recover = 1'b0;
    for (k = 0; k < 4000 && done !== 1'b1; k++) begin
      @(negedge clock);
      if (rd_valid === 1'b1) got_q.push_back(rd_data);
      if (nack === 1'b1) nack_n++;
    end
    check("done", {7'h0, done}, 8'h01);
    w = 8'h00;
    for (k = 0; k < 8 && k < bit_q.size(); k++) w = {w[6:0], bit_q[k]};
    if (!rec) check("address word", w, {a, rd});
  endtask
  task automatic expect_bytes(input logic [31:0] e, input int n);
    int k;
    check("byte count", 8'(got_q.size()), 8'(n));
    for (k = 0; k < n && k < got_q.size(); k++) begin
      check("read byte", got_q[k], e[31 - 8 * k -: 8]);
    end
  endtask
  // Busy rises a few cycles after done, so look only once the stop has landed
  task automatic wait_free();
    int k;
    repeat (8) @(negedge clock);
    check("busy after write", {7'h0, busy}, 8'h01);
    for (k = 0; k < 2 * WR_CYC && busy !== 1'b0; k++) @(negedge clock);
    check("busy end", {7'h0, busy}, 8'h00);
  endtask
  // ==========================================
  // Scenarios
  task automatic s_reset();
    check("standby", {7'h0, standby}, 8'h01);
    check("busy", {7'h0, busy}, 8'h00);
    check("cmd ready", {7'h0, cmd_ready}, 8'h01);
  endtask
  task automatic s_page();
    int k;
    for (k = 0; k < 8; k++) push(8'ha0 + 8'(k));
    check("fifo full", {7'h0, wr_ready}, 8'h00);
    run(1'b0, 1'b0, 7'h05, 8'h04);
    check("write nack", 8'(nack_n), 8'h00);
    k = 0;
    do begin
      run(1'b1, 1'b0, 7'h05, 8'h01);
      k++;
    end while (nack_n != 0 && k < 20);
    check("polls refused", 8'(k > 1), 8'h01);
    expect_bytes(32'ha0000000, 1);
    run(1'b0, 1'b0, 7'h10, 8'h04);
    check("fifo drained", {7'h0, wr_ready}, 8'h01);
    wait_free();
    run(1'b1, 1'b0, 7'h04, 8'h04);
    expect_bytes(32'ha3a0a1a2, 4);
    run(1'b1, 1'b0, 7'h10, 8'h04);
    expect_bytes(32'ha4a5a6a7, 4);
  endtask
  task automatic s_wrap();
    push(8'h3c);
    run(1'b0, 1'b0, 7'h7f, 8'h01);
    wait_free();
    push(8'h5a);
    run(1'b0, 1'b0, 7'h00, 8'h01);
    wait_free();
    run(1'b1, 1'b0, 7'h7f, 8'h02);
    expect_bytes(32'h3c5a0000, 2);
    run(1'b1, 1'b0, 7'h00, 8'h01);
    expect_bytes(32'h5a000000, 1);
    repeat (8) @(negedge clock);
    check("standby after read", {7'h0, standby}, 8'h01);
  endtask
  task automatic s_recover();
    run(1'b0, 1'b1, 7'h00, 8'h01);
    check("recovery nack", 8'(nack_n), 8'h00);
    run(1'b1, 1'b0, 7'h13, 8'h01);
    expect_bytes(32'ha7000000, 1);
  endtask
  // Count 6 is cut to one page of 4; count 0 still moves one byte
  task automatic s_clamp();
    int k;
    for (k = 0; k < 5; k++) push(8'h11 * 8'(k + 1));
    run(1'b0, 1'b0, 7'h20, 8'h06);
    wait_free();
    run(1'b0, 1'b0, 7'h24, 8'h00);
    wait_free();
    run(1'b1, 1'b0, 7'h21, 8'h04);
    expect_bytes(32'h22334455, 4);
  endtask
  // ==========================================
  // Main sequence and watchdog
  initial begin
    #2400000;
    n_mismatch++;
    give_verdict();
  end
  initial begin
    sys_rst = 1'b1;
    cmd_valid = 1'b0;
    cmd_read = 1'b0;
    cmd_recover = 1'b0;
    cmd_addr = 7'h00;
    cmd_count = 8'h00;
    wr_valid = 1'b0;
    wr_data = 8'h00;
    repeat (8) @(negedge clock);
    sys_rst = 1'b0;
    @(negedge clock);
    s_reset();
    s_page();
    s_wrap();
    s_recover();
    s_clamp();
    give_verdict();
  end
endmodule
